// ===== src/fes_defines.svh
// Constants for the flash erase and status sequencer controller
`ifndef FES_DEFINES_SVH
`define FES_DEFINES_SVH

// ****************************************************************
// Device command codes
// ****************************************************************
`define FES_CMD_READ_STATUS  8'h70
`define FES_CMD_BLOCK_SETUP  8'h20
`define FES_CMD_CHIP_SETUP   8'h30
`define FES_CMD_CONFIRM      8'hd0
`define FES_CMD_CLEAR_STATUS 8'h50
`define FES_CMD_READ_ARRAY   8'hff

// ****************************************************************
// Status bit positions
// ****************************************************************
`define FES_SR_READY   7
`define FES_SR_ESUSP   6
`define FES_SR_EFAIL   5
`define FES_SR_PFAIL   4
`define FES_SR_SUPPLY  3
`define FES_SR_PSUSP   2
`define FES_SR_PROTECT 1
`define FES_SR_RSVD    0
`define FES_SR_MASK    8'hfe

// ****************************************************************
// Controller register offsets
// ****************************************************************
`define FES_REG_CTRL   4'h0
`define FES_REG_ADDR   4'h1
`define FES_REG_STATUS 4'h2
`define FES_REG_RESULT 4'h3
`define FES_REG_FLASH  4'h4

// ****************************************************************
// Control field positions and reset values
// ****************************************************************
`define FES_CTRL_GO    0
`define FES_CTRL_CHIP  1
`define FES_CTRL_CHECK 2
`define FES_CTRL_CLEAR 3
`define FES_ADDR_RESET 20'h00000

// ****************************************************************
// Bus cycle timing, in ns, and derived clock counts
// ****************************************************************
`define FES_CLK_NS     20
`define FES_WE_NS      60
`define FES_OE_NS      100
`define FES_WE_CYC     ((`FES_WE_NS + `FES_CLK_NS - 1) / `FES_CLK_NS)
`define FES_OE_CYC     ((`FES_OE_NS + `FES_CLK_NS - 1) / `FES_CLK_NS)

`endif

// ===== src/fes_pkg.sv
// Types for the flash erase and status sequencer controller
package fes_pkg;

  typedef enum logic [2:0] {
    FES_RES_OK,
    FES_RES_SUPPLY,
    FES_RES_PROTECT,
    FES_RES_SEQ,
    FES_RES_ERASE,
    FES_RES_BUSY
  } fes_result_t;

endpackage : fes_pkg

// ===== src/fes_bus_cycle.sv
// One timed write or read cycle on the parallel flash bus
`timescale 1ns/1ps
`include "fes_defines.svh"

module fes_bus_cycle #(
  parameter int ADDR_W = 20
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic              start,
  input  wire logic              isWrite,
  input  wire logic [ADDR_W-1:0] addrIn,
  input  wire logic [7:0]        dataIn,
  input  wire logic [7:0]        flashDqIn,
  output logic                   done,
  output logic [7:0]             readData,
  output logic [ADDR_W-1:0]      flashAddr,
  output logic [7:0]             flashDqOut,
  output logic                   flashDqOe,
  output logic                   flashCeN,
  output logic                   flashWeN,
  output logic                   flashOeN
);

  // ****************************************************************
  // Cycle timer
  // ****************************************************************
  localparam logic [3:0] WE_CYC = 4'(`FES_WE_CYC);
  localparam logic [3:0] OE_CYC = 4'(`FES_OE_CYC);

  logic              busy_r, busy_nxt;
  logic              wr_r, wr_nxt;
  logic [3:0]        cnt_r, cnt_nxt;
  logic              done_r, done_nxt;
  logic [7:0]        rd_r, rd_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [7:0]        dq_r, dq_nxt;
  logic              ceN_r, ceN_nxt;
  logic              weN_r, weN_nxt;
  logic              oeN_r, oeN_nxt;
  logic              dqOe_r, dqOe_nxt;

  always_comb
  begin
    busy_nxt = busy_r;
    wr_nxt   = wr_r;
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    rd_nxt   = rd_r;
    addr_nxt = addr_r;
    dq_nxt   = dq_r;
    if (!busy_r && start)
    begin
      busy_nxt = 1'b1;
      wr_nxt   = isWrite;
      addr_nxt = addrIn;
      dq_nxt   = dataIn;
      cnt_nxt  = isWrite ? WE_CYC : OE_CYC;
    end
    else if (busy_r)
    begin
      if (cnt_r == 4'h1)
      begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        // Sampled at the end of the strobe, after access time
        if (!wr_r)
          rd_nxt = flashDqIn;
      end
      cnt_nxt = cnt_r - 4'h1;
    end
    // Strobes from flops, so the device pins never glitch
    ceN_nxt  = ~busy_nxt;
    weN_nxt  = ~(busy_nxt & wr_nxt);
    oeN_nxt  = ~(busy_nxt & ~wr_nxt);
    dqOe_nxt = busy_nxt & wr_nxt;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_r <= 1'b0;
      wr_r   <= 1'b0;
      cnt_r  <= 4'h0;
      done_r <= 1'b0;
      rd_r   <= 8'h00;
      addr_r <= '0;
      dq_r   <= 8'h00;
      ceN_r  <= 1'b1;
      weN_r  <= 1'b1;
      oeN_r  <= 1'b1;
      dqOe_r <= 1'b0;
    end
    else if (ce)
    begin
      busy_r <= busy_nxt;
      wr_r   <= wr_nxt;
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
      rd_r   <= rd_nxt;
      addr_r <= addr_nxt;
      dq_r   <= dq_nxt;
      ceN_r  <= ceN_nxt;
      weN_r  <= weN_nxt;
      oeN_r  <= oeN_nxt;
      dqOe_r <= dqOe_nxt;
    end
  end

  assign done       = done_r;
  assign readData   = rd_r;
  assign flashAddr  = addr_r;
  assign flashDqOut = dq_r;
  // Data held one cycle past the write strobe would need a gap; the
  // caller always leaves three idle clock cycles between cycles
  assign flashDqOe  = dqOe_r;
  assign flashCeN   = ceN_r;
  assign flashWeN   = weN_r;
  assign flashOeN   = oeN_r;

endmodule : fes_bus_cycle

// ===== src/fes_erase_ctrl.sv
// Host side erase sequencer and status checker for a parallel flash
`timescale 1ns/1ps
`include "fes_defines.svh"

// Behaviour
// - Bit 0 reserved, masked when polling
// - Bits 4 and 5 both: sequence error
// - Block erase: 20h then D0h in block
// - Chip erase: 30h then D0h, poll
// - Check after each or series of erasures
// - Check supply, protect, sequence, erase order
// - Clear status before retry after error
// - FFh returns device to array mode
module fes_erase_ctrl
  import fes_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  input  wire logic [3:0]           regAddr,
  input  wire logic [31:0]          regWdata,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic      [31:0]          regRdata,
  input  wire logic [7:0]           flashDqIn,
  output logic      [7:0]           flashDqOut,
  output logic                      flashDqOe,
  output logic      [ADDR_W-1:0]    flashAddr,
  output logic                      flashCeN,
  output logic                      flashWeN,
  output logic                      flashOeN,
  output logic                      busy,
  output fes_pkg::fes_result_t      result
);
  import fes_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_PRE_CMD, ST_PRE_RD, ST_SETUP, ST_CONFIRM,
    ST_POLL, ST_CLEAR, ST_ARRAY, ST_GAP
  } fes_state_t;

  // ****************************************************************
  // Bus cycle engine
  // ****************************************************************
  logic              cycStart, cycWrite, cycDone;
  logic [7:0]        cycData, cycRdata;
  logic [ADDR_W-1:0] cycAddr;
  logic [ADDR_W-1:0] pAddr;
  logic [7:0]        pDq;
  logic              pDqOe, pCeN, pWeN, pOeN;

  fes_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
    .clk        (clk),
    .rstn       (rstn),
    .ce         (ce),
    .start      (cycStart),
    .isWrite    (cycWrite),
    .addrIn     (cycAddr),
    .dataIn     (cycData),
    .flashDqIn  (flashDqIn),
    .done       (cycDone),
    .readData   (cycRdata),
    .flashAddr  (pAddr),
    .flashDqOut (pDq),
    .flashDqOe  (pDqOe),
    .flashCeN   (pCeN),
    .flashWeN   (pWeN),
    .flashOeN   (pOeN)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  fes_state_t        state_r, state_nxt, after_r, after_nxt;
  logic              issued_r, issued_nxt;
  logic              chip_r, chip_nxt;
  logic              check_r, check_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [7:0]        stat_r, stat_nxt;
  fes_result_t       res_r, res_nxt;
  logic              busy_r, busy_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  logic [7:0]        rawStat;

  // Reserved bit never reaches any decision
  assign rawStat = cycRdata & `FES_SR_MASK;

  function automatic fes_result_t judge(input logic [7:0] s);
    fes_result_t r;
    r = FES_RES_OK;
    // Order matters: a supply abort also sets failure bits
    if (s[`FES_SR_SUPPLY])
      r = FES_RES_SUPPLY;
    else if (s[`FES_SR_PROTECT])
      r = FES_RES_PROTECT;
    else if (s[`FES_SR_EFAIL] && s[`FES_SR_PFAIL])
      r = FES_RES_SEQ;
    else if (s[`FES_SR_EFAIL])
      r = FES_RES_ERASE;
    return r;
  endfunction : judge

  always_comb
  begin
    state_nxt  = state_r;
    after_nxt  = after_r;
    issued_nxt = 1'b0;
    chip_nxt   = chip_r;
    check_nxt  = check_r;
    addr_nxt   = addr_r;
    stat_nxt   = stat_r;
    res_nxt    = res_r;
    busy_nxt   = busy_r;
    rdata_nxt  = 32'h0;
    cycStart   = 1'b0;
    cycWrite   = 1'b1;
    cycData    = `FES_CMD_READ_STATUS;
    cycAddr    = '0;
    case (state_r)
      ST_IDLE:
      begin
        if (regWr && regAddr == `FES_REG_ADDR)
          addr_nxt = regWdata[ADDR_W-1:0];
        if (regWr && regAddr == `FES_REG_CTRL)
        begin
          if (regWdata[`FES_CTRL_CLEAR])
          begin
            busy_nxt  = 1'b1;
            state_nxt = ST_CLEAR;
          end
          else if (regWdata[`FES_CTRL_GO])
          begin
            busy_nxt  = 1'b1;
            chip_nxt  = regWdata[`FES_CTRL_CHIP];
            // Chip erase is always checked; block may defer to a series
            check_nxt = regWdata[`FES_CTRL_CHECK] | regWdata[`FES_CTRL_CHIP];
            res_nxt   = FES_RES_BUSY;
            state_nxt = ST_PRE_CMD;
          end
        end
      end
      ST_PRE_CMD:
      begin
        cycStart   = !issued_r;
        issued_nxt = !cycDone;
        if (cycDone)
        begin
          after_nxt = ST_PRE_RD;
          state_nxt = ST_GAP;
        end
      end
      ST_PRE_RD, ST_POLL:
      begin
        cycStart   = !issued_r;
        cycWrite   = 1'b0;
        issued_nxt = !cycDone;
        // Device keeps answering status, no reissue of 70h needed
        if (cycDone)
        begin
          stat_nxt  = rawStat;
          after_nxt = state_r;
          if (rawStat[`FES_SR_READY])
            after_nxt = (state_r == ST_PRE_RD) ? ST_SETUP : ST_ARRAY;
          if (rawStat[`FES_SR_READY] && state_r == ST_POLL)
            res_nxt = check_r ? judge(rawStat) : FES_RES_OK;
          state_nxt = ST_GAP;
        end
      end
      ST_SETUP:
      begin
        cycStart   = !issued_r;
        cycData    = chip_r ? `FES_CMD_CHIP_SETUP : `FES_CMD_BLOCK_SETUP;
        issued_nxt = !cycDone;
        if (cycDone)
        begin
          after_nxt = ST_CONFIRM;
          state_nxt = ST_GAP;
        end
      end
      ST_CONFIRM:
      begin
        cycStart   = !issued_r;
        cycData    = `FES_CMD_CONFIRM;
        cycAddr    = chip_r ? '0 : addr_r;
        issued_nxt = !cycDone;
        if (cycDone)
        begin
          after_nxt = ST_POLL;
          state_nxt = ST_GAP;
        end
      end
      ST_CLEAR:
      begin
        cycStart   = !issued_r;
        cycData    = `FES_CMD_CLEAR_STATUS;
        issued_nxt = !cycDone;
        if (cycDone)
        begin
          res_nxt   = FES_RES_OK;
          after_nxt = ST_ARRAY;
          state_nxt = ST_GAP;
        end
      end
      ST_ARRAY:
      begin
        cycStart   = !issued_r;
        cycData    = `FES_CMD_READ_ARRAY;
        issued_nxt = !cycDone;
        if (cycDone)
        begin
          after_nxt = ST_IDLE;
          state_nxt = ST_GAP;
        end
      end
      ST_GAP:
      begin
        state_nxt = after_r;
        if (after_r == ST_IDLE)
          busy_nxt = 1'b0;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
    if (regRd)
    begin
      case (regAddr)
        `FES_REG_ADDR:   rdata_nxt = 32'(addr_r);
        `FES_REG_STATUS: rdata_nxt = {31'h0, busy_r};
        `FES_REG_RESULT: rdata_nxt = {29'h0, res_r};
        // Suspend bits shown raw for software
        `FES_REG_FLASH:  rdata_nxt = {24'h0, stat_r};
        default:         rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r  <= ST_IDLE;
      after_r  <= ST_IDLE;
      issued_r <= 1'b0;
      chip_r   <= 1'b0;
      check_r  <= 1'b0;
      addr_r   <= `FES_ADDR_RESET;
      stat_r   <= 8'h00;
      res_r    <= FES_RES_OK;
      busy_r   <= 1'b0;
      rdata_r  <= 32'h0;
    end
    else if (ce)
    begin
      state_r  <= state_nxt;
      after_r  <= after_nxt;
      issued_r <= issued_nxt;
      chip_r   <= chip_nxt;
      check_r  <= check_nxt;
      addr_r   <= addr_nxt;
      stat_r   <= stat_nxt;
      res_r    <= res_nxt;
      busy_r   <= busy_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  assign regRdata   = rdata_r;
  assign busy       = busy_r;
  assign result     = res_r;
  assign flashDqOut = pDq;
  assign flashDqOe  = pDqOe;
  assign flashAddr  = pAddr;
  assign flashCeN   = pCeN;
  assign flashWeN   = pWeN;
  assign flashOeN   = pOeN;

endmodule : fes_erase_ctrl

// ===== verif/fes_erase_ctrl_properties.sv
// Concurrent checks on the erase controller ports
`timescale 1ns/1ps
module fes_erase_ctrl_properties
  import fes_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              ce,
  input wire logic [3:0]        regAddr,
  input wire logic [31:0]       regWdata,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [31:0]       regRdata,
  input wire logic [7:0]        flashDqIn,
  input wire logic [7:0]        flashDqOut,
  input wire logic              flashDqOe,
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic              flashCeN,
  input wire logic              flashWeN,
  input wire logic              flashOeN,
  input wire logic              busy,
  input fes_pkg::fes_result_t   result
);
  // ****************************************************************
  // Last command written to the device
  // ****************************************************************
  logic [7:0] lastCmd_r;
  logic       prevWeN_r;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      lastCmd_r <= 8'h00;
      prevWeN_r <= 1'b1;
    end
    else
    begin
      prevWeN_r <= flashWeN;
      if (prevWeN_r && !flashWeN)
        lastCmd_r <= flashDqOut;
    end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_wrPulse;
    !flashWeN[*3] ##1 flashWeN;
  endsequence
  sequence s_rdPulse;
    !flashOeN[*5] ##1 flashOeN;
  endsequence
  sequence s_goWrite;
    ce && regWr && regAddr == 4'h0 && regWdata[0] && !regWdata[3] && !busy;
  endsequence

  a_we_width: assert property ($fell(flashWeN) |-> s_wrPulse)
    else $error("write strobe width wrong");
  a_oe_width: assert property ($fell(flashOeN) |-> s_rdPulse)
    else $error("read strobe width wrong");
  a_write_drive: assert property (!flashWeN |-> flashOeN && !flashCeN && flashDqOe)
    else $error("write cycle badly framed");
  a_read_release: assert property (!flashOeN |-> !flashDqOe && !flashCeN)
    else $error("bus driven during read");
  a_go_busy: assert property (s_goWrite |=> busy && result == FES_RES_BUSY)
    else $error("go not taken");
  a_go_status: assert property (s_goWrite |=> ##1 (!flashWeN && flashDqOut == 8'h70))
    else $error("erase not opened by status command");
  a_confirm_order: assert property ($fell(flashWeN) && flashDqOut == 8'hd0 |->
    lastCmd_r inside {8'h20, 8'h30})
    else $error("confirm without setup");
  a_end_array: assert property ($fell(busy) |-> lastCmd_r == 8'hff)
    else $error("sequence did not end in array mode");
endmodule : fes_erase_ctrl_properties

bind fes_erase_ctrl fes_erase_ctrl_properties #(.ADDR_W(ADDR_W)) u_props (
  .clk(clk), .rstn(rstn), .ce(ce), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .flashDqIn(flashDqIn),
  .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashAddr(flashAddr),
  .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN),
  .busy(busy), .result(result)
);

// ===== verif/fes_flash_model.sv
// Behavioural parallel flash answering erase and status commands
`timescale 1ns/1ps
module fes_flash_model (
  input  wire logic        clk,
  input  wire logic        ceN,
  input  wire logic        weN,
  input  wire logic        oeN,
  input  wire logic [19:0] addr,
  input  wire logic [7:0]  dqIn,
  input  wire logic [7:0]  errInject,
  input  wire logic [7:0]  busyLen,
  output logic      [7:0]  dqOut
);
  logic [7:0]  stat = 8'h80;
  logic [7:0]  cmdL = 8'h00, lastOut = 8'h00, cnt = 8'h00;
  logic [19:0] adrL = 20'h0, confAddr = 20'h0;
  logic        wasLow = 1'b0, setup = 1'b0, stMode = 1'b0;

  // ****************************************************************
  // Reads: busy status has junk low bits, released bus inverts
  // ****************************************************************
  always_comb
    if (ceN || oeN)
      dqOut = ~lastOut;
    else if (!stMode)
      dqOut = 8'ha5;
    else if (stat[7])
      dqOut = {stat[7:1], 1'b1};
    else
      dqOut = {1'b0, ~stat[6:0]};

  // Suspend flags never set: no suspend command modelled
  always @(posedge clk)
  begin
    if (!ceN && !oeN)
      lastOut <= dqOut;
    wasLow <= !ceN && !weN;
    if (!ceN && !weN)
    begin
      cmdL <= dqIn;
      adrL <= addr;
    end
    if (cnt != 8'h0)
      cnt <= cnt - 8'h1;
    // Injected faults applied only as the operation ends
    if (cnt == 8'h1)
      stat <= stat | 8'h80 | (errInject & 8'h3a);
    if (wasLow && weN)
    begin
      setup <= cmdL == 8'h20 || cmdL == 8'h30;
      stMode <= cmdL != 8'hff;
      if (cmdL == 8'h50)
        stat <= stat & 8'hc5;
      if (cmdL == 8'hd0 && setup)
      begin
        stat[7] <= 1'b0;
        cnt <= busyLen;
        confAddr <= adrL;
      end
      else if (cmdL == 8'hd0)
        stat[5:4] <= 2'b11;
    end
  end
endmodule : fes_flash_model

// ===== verif/tb_top.sv
// Self-checking bench for the erase controller with a flash model
`timescale 1ns/1ps
module tb_top;
  import fes_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0, rdSeen = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic        ceIn = 1'b1;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic [7:0]  flashDqIn, flashDqOut, errInject = 8'h00, busyLen = 8'h04;
  logic [19:0] flashAddr, blk;
  logic        flashDqOe, flashCeN, flashWeN, flashOeN, busy;
  fes_result_t result;
  logic [31:0] expQ[$];
  int          failCount = 0, checkCount = 0;
  logic [7:0]  errs[6] = '{8'h08, 8'h02, 8'h30, 8'h20, 8'h0a, 8'h32};
  fes_result_t ress[6] = '{FES_RES_SUPPLY, FES_RES_PROTECT, FES_RES_SEQ,
                           FES_RES_ERASE, FES_RES_SUPPLY, FES_RES_PROTECT};

  always #10 clk = ~clk;

  fes_erase_ctrl u_dut (.clk(clk), .rstn(rstn), .ce(ceIn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .flashDqIn(flashDqIn), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
    .flashAddr(flashAddr), .flashCeN(flashCeN), .flashWeN(flashWeN),
    .flashOeN(flashOeN), .busy(busy), .result(result));
  fes_flash_model u_flash (.clk(clk), .ceN(flashCeN), .weN(flashWeN), .oeN(flashOeN),
    .addr(flashAddr), .dqIn(flashDqOut), .errInject(errInject), .busyLen(busyLen),
    .dqOut(flashDqIn));

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic testDone;
    $display("checks %0d failures %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : testDone

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Read data appear one cycle after the strobe only
  always @(posedge clk)
  begin
    if (rdSeen)
      check("regRdata", regRdata, expQ.pop_front());
    rdSeen = regRd;
  end

  task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask : regWrite

  task automatic regRead(input logic [3:0] a, input logic [31:0] exp);
    expQ.push_back(exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
  endtask : regRead

  task automatic waitIdle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 5000)
    begin
      failCount++;
      testDone();
    end
  endtask : waitIdle

  task automatic runOp(input logic [31:0] ctl, input logic [7:0] err, input fes_result_t res);
    errInject <= err;
    busyLen <= 8'($urandom_range(40, 1));
    regWrite(4'h0, ctl);
    waitIdle();
    check("result", {29'h0, result}, {29'h0, res});
    regRead(4'h3, {29'h0, res});
  endtask : runOp

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    void'($urandom(32'hb615ad87));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    regRead(4'h2, 32'h0);
    regRead(4'hf, 32'h0);
    // Clock enable low: a go order must be lost, not queued
    ceIn <= 1'b0;
    regWrite(4'h0, 32'h5);
    ceIn <= 1'b1;
    check("frozen busy", {31'h0, busy}, 32'h0);
    blk = 20'($urandom);
    regWrite(4'h1, {12'h0, blk});
    runOp(32'h5, 8'h00, FES_RES_OK);
    check("confirm address", {12'h0, u_flash.confAddr}, {12'h0, blk});
    check("array mode", {31'h0, u_flash.stMode}, 32'h0);
    regRead(4'h4, 32'h80);
    // Unchecked failure must survive to the next checked erase
    runOp(32'h1, 8'h20, FES_RES_OK);
    errInject <= 8'h00;
    regWrite(4'h0, 32'h5);
    regWrite(4'h1, 32'h0);
    waitIdle();
    check("sticky result", {29'h0, result}, {29'h0, FES_RES_ERASE});
    regRead(4'h1, {12'h0, blk});
    regWrite(4'h0, 32'h8);
    waitIdle();
    check("cleared status", {24'h0, u_flash.stat}, 32'h80);
    for (int i = 0; i < 6; i++)
    begin
      runOp(32'h7, errs[i], ress[i]);
      check("chip address", {12'h0, u_flash.confAddr}, 32'h0);
      regRead(4'h4, {24'h0, 8'h80 | errs[i]});
      regWrite(4'h0, 32'h8);
      waitIdle();
      check("cleared status", {24'h0, u_flash.stat}, 32'h80);
    end
    testDone();
  end
endmodule : tb_top
